// >>> hdl/sstf_supply_fsm.sv
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////////////////////
module sstf_supply_fsm
   import sstf_pkg::*;
#(
   parameter int STEP_CYC = TR_STEP_US * 1000 / CLK_NS
)
(
   // clock, reset, enable
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic ce,
   // spi link
   input wire logic spi_sck,
   input wire logic spi_mosi,
   input wire logic spi_chip_select,
   // asynchronous inputs
   input wire logic power_on_release,
   input wire logic edge_wake_input,
   input wire logic level_resume_input,
   input wire logic ldo_cur_low,
   input wire logic ldo_cur_high,
   input wire logic wake_tmr_expired,
   input wire logic severe_fail,
   // configuration and flag clear
   input wire sstf_cfg_s cfg,
   input wire logic [4:0] wake_flags_clr,
   // state outputs
   output logic reset_output,
   output logic primary_safe_state_out,
   output logic secondary_safe_state_out,
   output logic irq_output_pin,
   output logic [2:0] sup_en,
   output logic [2:0] sup_restart,
   output logic [3:0] reg_en,
   output logic wake_tmr_run,
   output logic [4:0] wake_source_flags,
   output logic [9:0] wwd_first_win_ms,
   output logic [2:0] state_code
);
   ////////////////////////////////////////////////////////////////////////////
   if (STEP_CYC < 1 || 16 * STEP_CYC >= 2 ** CNT_W)
   begin : g_chk
      $error("STEP_CYC out of range");
   end

   sstf_st_s r;
   sstf_st_s n;
   logic [7:0] cmd_hold;
   logic byte_tgl;
   logic cs_rise;
   logic cs_fall;
   logic cmd_ok;
   logic edge_wk;
   logic lvl_wk;
   logic fail;
   logic tr_done;
   logic to_wake;
   logic [4:0] wk_set;

   // delay field n means (n + 1) steps of 100 us
   function automatic logic [CNT_W-1:0] steps_to_cyc(input logic [3:0] f);
      return CNT_W'((int'(f) + 1) * STEP_CYC);
   endfunction : steps_to_cyc

   function automatic logic in_sleep(input sstf_state_e s);
      return (s == ST_SLP_TR) || (s == ST_SLEEP);
   endfunction : in_sleep

   // spi bits are gathered on the link clock
   sstf_spi_link u_link (
      .spi_sck(spi_sck),
      .spi_mosi(spi_mosi),
      .rst(rst),
      .cmd_hold(cmd_hold),
      .byte_tgl(byte_tgl)
   );

   ////////////////////////////////////////////////////////////////////////////
   // event decode from the second and third sync stages; chip select from the third and fourth
   always_comb
   begin
      cs_rise = r.s3[SY_CS] && !r.cs4;
      cs_fall = !r.s3[SY_CS] && r.cs4;
      // a frame counts only with exactly one whole byte in it
      cmd_ok = cs_rise && (r.bytes == 2'h1);
      edge_wk = r.s2[SY_EDGE] && !r.s3[SY_EDGE];
      lvl_wk = r.s2[SY_LEVEL];
      fail = r.s2[SY_FAIL];
      tr_done = (r.tr_cnt == '0);
   end

   ////////////////////////////////////////////////////////////////////////////
   // next-state logic
   always_comb
   begin
      n = r;
      to_wake = 1'b0;
      wk_set = '0;
      n.s1 = {byte_tgl, spi_chip_select, severe_fail, wake_tmr_expired,
              ldo_cur_high, ldo_cur_low, level_resume_input, edge_wake_input,
              power_on_release};
      n.s2 = r.s1;
      n.s3 = r.s2;
      // cs is one stage later so the byte toggle lands first
      n.cs4 = r.s3[SY_CS];
      n.restart = '0;
      // take the byte once its toggle has crossed; it is stable by now
      if (r.s2[SY_TGL] != r.s3[SY_TGL])
      begin
         n.cmd = cmd_hold;
         if (r.bytes != 2'h2)
            n.bytes = r.bytes + 2'h1;
      end
      if (cs_fall)
         n.bytes = '0;
      // delay counters run down to zero and rest there
      if (r.tr_cnt != '0)
         n.tr_cnt = r.tr_cnt - CNT_W'(1);
      if (r.ss2_cnt != '0)
         n.ss2_cnt = r.ss2_cnt - CNT_W'(1);
      if (r.irq_cnt != '0)
         n.irq_cnt = r.irq_cnt - 8'h01;
      // restart the supervisors as the interrupt pulse falls
      if (r.irq_cnt == 8'h01 && r.state == ST_WAKE)
      begin
         n.restart[SUP_WWD] = r.saved_sup[SUP_WWD] && !r.slp_sup[SUP_WWD];
         n.restart[SUP_FWD] = r.saved_sup[SUP_FWD];
         n.restart[SUP_ERR] = r.saved_sup[SUP_ERR];
      end

      case (r.state)
         ST_PDOWN:
         begin
            if (r.s2[SY_POR])
               n.state = ST_INIT;
         end
         ST_INIT:
         begin
            if (cmd_ok && r.cmd == CMD_GO_NORMAL)
               n.state = ST_NORMAL;
         end
         ST_NORMAL:
         begin
            if (cmd_ok && r.cmd == CMD_GO_SLEEP)
            begin
               n.state = ST_SLP_TR;
               n.tr_cnt = steps_to_cyc(cfg.tr_delay);
               n.ss2_cnt = steps_to_cyc(cfg.ss2_delay);
               // keep the normal settings so wake can put them back
               n.saved_sup = cfg.norm_sup;
               n.saved_reg = cfg.norm_reg;
               n.slp_sup = cfg.sleep_sup;
               n.slp_reg = cfg.sleep_reg;
            end
         end
         ST_SLP_TR:
         begin
            // wake causes are checked before completion
            if (edge_wk || lvl_wk)
            begin
               to_wake = 1'b1;
               wk_set[WK_EDGE] = edge_wk;
               wk_set[WK_LEVEL] = lvl_wk;
            end
            else if (cfg.cur_mon_sel && tr_done && !r.s2[SY_ILOW])
            begin
               to_wake = 1'b1;
               wk_set[WK_CUR] = 1'b1;
            end
            else if (cfg.cur_mon_sel ? r.s2[SY_ILOW] : tr_done)
               n.state = ST_SLEEP;
         end
         ST_SLEEP:
         begin
            wk_set[WK_SPI] = cmd_ok && r.cmd == CMD_GO_WAKE;
            wk_set[WK_EDGE] = edge_wk;
            wk_set[WK_LEVEL] = lvl_wk;
            wk_set[WK_CUR] = r.s2[SY_IHIGH];
            wk_set[WK_TMR] = r.s2[SY_WTMR] && cfg.wake_tmr_en;
            to_wake = (wk_set != '0);
         end
         ST_WAKE:
         begin
            n.state = ST_WAKE;
         end
         ST_FAIL:
         begin
            n.state = ST_FAIL;
         end
         default:
         begin
            n.state = ST_FAIL;
         end
      endcase

      // wake is entered at once, with a fresh interrupt pulse
      if (to_wake)
      begin
         n.state = ST_WAKE;
         n.irq_cnt = IRQ_CYC;
         n.win_ms = cfg.wd_cyc_sel ? WWD_LONG_MS : WWD_SHORT_MS;
      end
      // a severe failure overrides everything and only reset leaves it
      if (fail)
      begin
         n.state = ST_FAIL;
         n.irq_cnt = '0;
         n.restart = '0;
      end

      // set wins over a clear in the same cycle
      n.wk_flags = (r.wk_flags & ~wake_flags_clr) | wk_set;

      // outputs follow the next state so they leave flip-flops
      n.rst_out = !(n.state == ST_PDOWN || n.state == ST_FAIL);
      n.ss1 = (n.state == ST_NORMAL);
      n.ss2 = (n.state == ST_NORMAL) ||
              (n.state == ST_SLP_TR && n.ss2_cnt != '0);
      n.irq = (n.irq_cnt != '0);
      n.wtmr_run = in_sleep(n.state) && cfg.wake_tmr_en;
      case (n.state)
         ST_INIT, ST_NORMAL:
         begin
            n.sup_en = cfg.norm_sup;
            n.reg_en = cfg.norm_reg;
         end
         ST_SLP_TR, ST_SLEEP:
         begin
            n.sup_en = n.slp_sup;
            n.reg_en = n.slp_reg;
         end
         ST_WAKE:
         begin
            n.sup_en = n.saved_sup;
            n.reg_en = n.saved_reg;
         end
         default:
         begin
            n.sup_en = '0;
            n.reg_en = '0;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // single state register; ce low freezes everything
   always_ff @(posedge clk_sys)
   begin
      if (rst)
         r <= ST_RST;
      else if (ce)
         r <= n;
   end

   assign reset_output = r.rst_out;
   assign primary_safe_state_out = r.ss1;
   assign secondary_safe_state_out = r.ss2;
   assign irq_output_pin = r.irq;
   assign sup_en = r.sup_en;
   assign sup_restart = r.restart;
   assign reg_en = r.reg_en;
   assign wake_tmr_run = r.wtmr_run;
   assign wake_source_flags = r.wk_flags;
   assign wwd_first_win_ms = r.win_ms;
   assign state_code = r.state;

   ////////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (rst);

   property p_fail_off;
      r.state == ST_FAIL |-> !r.rst_out && !r.ss1 && !r.ss2 &&
         r.reg_en == '0 && r.sup_en == '0 && !r.wtmr_run;
   endproperty
   a_fail_off: assert property (p_fail_off)
      else $error("failsafe outputs not off");

   property p_init_normal;
      r.state == ST_NORMAL && $past(r.state) == ST_INIT |->
         $past(cmd_ok) && $past(r.cmd) == CMD_GO_NORMAL;
   endproperty
   a_init_normal: assert property (p_init_normal)
      else $error("normal entered without command");

   property p_por;
      r.state == ST_INIT && $past(r.state) == ST_PDOWN |-> $past(r.s2[SY_POR]);
   endproperty
   a_por: assert property (p_por)
      else $error("init left power-down without release");

   property p_ss_rise;
      r.state == ST_NORMAL && $past(r.state) == ST_INIT |->
         r.ss1 && r.ss2 && r.rst_out && $past(r.rst_out);
   endproperty
   a_ss_rise: assert property (p_ss_rise)
      else $error("safe outputs not raised together");

   property p_sleep_start;
      r.state == ST_SLP_TR && $past(r.state) == ST_NORMAL |->
         !r.ss1 && r.rst_out && $past(cs_rise);
   endproperty
   a_sleep_start: assert property (p_sleep_start)
      else $error("sleep transition entry wrong");

   property p_abs_timer;
      r.state == ST_SLEEP && $past(r.state) == ST_SLP_TR && !$past(cfg.cur_mon_sel)
         |-> $past(r.tr_cnt) == '0;
   endproperty
   a_abs_timer: assert property (p_abs_timer)
      else $error("sleep entered before delay expiry");

   property p_tr_wake;
      ce && !fail && r.state == ST_SLP_TR && (edge_wk || lvl_wk) |=>
         r.state == ST_WAKE ##1 r.irq;
   endproperty
   a_tr_wake: assert property (p_tr_wake)
      else $error("wake input in transition ignored");

   property p_cur_timeout;
      ce && !fail && r.state == ST_SLP_TR && cfg.cur_mon_sel && tr_done &&
         !r.s2[SY_ILOW] |=> r.state == ST_WAKE && r.wk_flags[WK_CUR];
   endproperty
   a_cur_timeout: assert property (p_cur_timeout)
      else $error("current timeout did not wake");

   property p_ss2_delay;
      $fell(r.ss2) && r.state == ST_SLP_TR |-> $past(r.ss2_cnt) == CNT_W'(1);
   endproperty
   a_ss2_delay: assert property (p_ss2_delay)
      else $error("secondary safe output fell early");

   property p_irq_wake;
      $rose(r.irq) |-> r.state == ST_WAKE && $past(r.state) != ST_WAKE;
   endproperty
   a_irq_wake: assert property (p_irq_wake)
      else $error("interrupt without wake entry");

   property p_restart;
      $fell(r.irq) && r.state == ST_WAKE |-> r.restart[SUP_FWD] == r.saved_sup[SUP_FWD]
         && r.restart[SUP_ERR] == r.saved_sup[SUP_ERR];
   endproperty
   a_restart: assert property (p_restart)
      else $error("supervision restart not at interrupt fall");

   property p_low_safe;
      // the wake timer may run in sleep when enabled, but never in wake
      r.state == ST_SLEEP || r.state == ST_WAKE |->
         !r.ss1 && !r.ss2 && !(r.state == ST_WAKE && r.wtmr_run);
   endproperty
   a_low_safe: assert property (p_low_safe)
      else $error("safe outputs high in sleep or wake");

endmodule : sstf_supply_fsm

// >>> hdl/sstf_pkg.sv
// How it works
// - failsafe turns off regulators, wake timer, supervision; reset and safe outputs low.
// - spi state changes start only at chip-select rise ending a valid frame.
// - power-down goes to init only while power-on release is asserted.
// - init goes to normal only on go-to-normal command at chip-select rise.
// - init to normal keeps reset high and raises both safe outputs together.
// - go-to-sleep in normal drops primary safe output, enters sleep transition.
// - supervision checking switches to sleep configuration at that chip-select rise.
// - absolute timer mode enters sleep when transition delay (100 us steps) expires.
// - current monitor mode enters sleep when core regulator current falls below threshold.
// - edge or level wake during sleep transition returns to wake with interrupt.
// - current still high at delay expiry returns to wake with interrupt.
// - secondary safe output drops after its own delay from transition start, or on leaving the transition if that comes first.
// - reset output stays high through the sleep transition.
// - sleep leaves for wake on command, wake input, current, wake timer.
// - sleep to wake is immediate, pulses interrupt, records wake source flags.
// - wake restores supervision and regulator settings held in normal before sleep.
// - window watchdog restarts at interrupt fall if active before sleep and off in sleep; first window 600 or 60 ms.
// - heartbeat watchdog timer restarts at interrupt fall if active before sleep.
// - error pin supervision restarts at interrupt fall if active before sleep; toggling due within 10 ms.
// - both safe outputs stay low in sleep and wake.
// - entering wake raises interrupt; wake timer stays off in wake.
package sstf_pkg;
   // operating states
   typedef enum logic [2:0] {
      ST_PDOWN = 3'h0,
      ST_INIT = 3'h1,
      ST_NORMAL = 3'h2,
      ST_SLP_TR = 3'h3,
      ST_SLEEP = 3'h4,
      ST_WAKE = 3'h5,
      ST_FAIL = 3'h6
   } sstf_state_e;
   // spi command bytes
   localparam logic [7:0] CMD_GO_NORMAL = 8'h01;
   localparam logic [7:0] CMD_GO_SLEEP = 8'h02;
   localparam logic [7:0] CMD_GO_WAKE = 8'h03;
   // timing
   localparam int CLK_NS = 8;
   localparam int TR_STEP_US = 100;
   localparam logic [3:0] TR_DELAY_RST = 4'h8;
   localparam int IRQ_PULSE_NS = 1000;
   localparam logic [7:0] IRQ_CYC = 8'((IRQ_PULSE_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [9:0] WWD_LONG_MS = 10'h258;
   localparam logic [9:0] WWD_SHORT_MS = 10'h03C;
   // synchroniser bit positions
   localparam int SY_POR = 0;
   localparam int SY_EDGE = 1;
   localparam int SY_LEVEL = 2;
   localparam int SY_ILOW = 3;
   localparam int SY_IHIGH = 4;
   localparam int SY_WTMR = 5;
   localparam int SY_FAIL = 6;
   localparam int SY_CS = 7;
   localparam int SY_TGL = 8;
   localparam int NSYNC = 9;
   // wake source flag positions
   localparam int WK_SPI = 0;
   localparam int WK_EDGE = 1;
   localparam int WK_LEVEL = 2;
   localparam int WK_CUR = 3;
   localparam int WK_TMR = 4;
   // supervision positions
   localparam int SUP_WWD = 0;
   localparam int SUP_FWD = 1;
   localparam int SUP_ERR = 2;
   localparam int CNT_W = 18;
   // configuration from the register side
   typedef struct packed {
      logic [3:0] tr_delay;
      logic [3:0] ss2_delay;
      logic cur_mon_sel;
      logic wake_tmr_en;
      logic wd_cyc_sel;
      logic [2:0] norm_sup;
      logic [2:0] sleep_sup;
      logic [3:0] norm_reg;
      logic [3:0] sleep_reg;
   } sstf_cfg_s;
   // link side state
   typedef struct packed {
      logic [6:0] sh;
      logic [2:0] cnt;
      logic [7:0] hold;
      logic tgl;
   } sstf_lnk_s;
   localparam sstf_lnk_s LNK_RST = '0;
   // sequencer state
   typedef struct packed {
      logic [NSYNC-1:0] s1;
      logic [NSYNC-1:0] s2;
      logic [NSYNC-1:0] s3;
      logic cs4;
      sstf_state_e state;
      logic [7:0] cmd;
      logic [1:0] bytes;
      logic [CNT_W-1:0] tr_cnt;
      logic [CNT_W-1:0] ss2_cnt;
      logic [7:0] irq_cnt;
      logic [2:0] saved_sup;
      logic [3:0] saved_reg;
      logic [2:0] slp_sup;
      logic [3:0] slp_reg;
      logic [4:0] wk_flags;
      logic rst_out;
      logic ss1;
      logic ss2;
      logic irq;
      logic [2:0] sup_en;
      logic [2:0] restart;
      logic [3:0] reg_en;
      logic wtmr_run;
      logic [9:0] win_ms;
   } sstf_st_s;
   localparam sstf_st_s ST_RST = '0;
endpackage : sstf_pkg

// >>> hdl/sstf_spi_link.sv
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////////////////////
module sstf_spi_link
   import sstf_pkg::*;
(
   // link pins
   input wire logic spi_sck,
   input wire logic spi_mosi,
   input wire logic rst,
   // towards the sequencer domain
   output logic [7:0] cmd_hold,
   output logic byte_tgl
);
   sstf_lnk_s r;
   sstf_lnk_s n;
   logic [7:0] shifted;

   // msb first; the held byte stays still until the next whole byte clocks in
   always_comb
   begin
      n = r;
      shifted = {r.sh, spi_mosi};
      n.sh = shifted[6:0];
      n.cnt = r.cnt + 3'h1;
      if (r.cnt == 3'h7)
      begin
         n.hold = shifted;
         n.tgl = !r.tgl; // event crosses as a toggle
      end
   end

   // sck only runs inside frames, so reset is taken without it
   always_ff @(posedge spi_sck or posedge rst)
   begin
      if (rst)
         r <= LNK_RST;
      else
         r <= n;
   end

   assign cmd_hold = r.hold;
   assign byte_tgl = r.tgl;
endmodule : sstf_spi_link

// >>> tb/sstf_spi_ctrl.sv
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////////////////////
module sstf_spi_ctrl
   import sstf_pkg::*;
(
   // link pins
   output logic spi_sck,
   output logic spi_mosi,
   output logic spi_chip_select
);
   logic lclk;
   logic sck_en;

   // link clock runs in the model but reaches the pin only inside frames
   initial
   begin
      lclk = 1'b0;
      #5;
      forever #16 lclk = ~lclk;
   end
   assign spi_sck = lclk & sck_en;

   // idle levels at time zero
   initial
   begin
      sck_en = 1'b0;
      spi_mosi = 1'b0;
      spi_chip_select = 1'b1;
   end

   // frame of whole bytes, msb first; enable moves only while lclk is low
   task automatic send(input logic [7:0] cmd, input int nb);
      @(negedge lclk);
      spi_chip_select = 1'b0;
      for (int i = 0; i < 8 * nb; i++)
      begin
         spi_mosi = cmd[7 - i % 8];
         sck_en = 1'b1;
         @(negedge lclk);
      end
      sck_en = 1'b0;
      spi_mosi = ~spi_mosi; // released line shows no stale bit
      @(negedge lclk);
      spi_chip_select = 1'b1;
      #100; // gap well above six system cycles
   endtask : send

   // services are taken as done; settle time before asking for normal
   task automatic go_normal();
      #60us;
      send(CMD_GO_NORMAL, 1);
   endtask : go_normal
endmodule : sstf_spi_ctrl

// >>> tb/tb_sstf_supply_fsm.sv
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////////////////////
module tb_sstf_supply_fsm
   import sstf_pkg::*;
;
   logic clk_sys, rst, ce, spi_sck, spi_mosi, spi_chip_select;
   logic power_on_release, edge_wake_input, level_resume_input;
   logic ldo_cur_low, ldo_cur_high, wake_tmr_expired, severe_fail;
   sstf_cfg_s cfg;
   logic [4:0] wake_flags_clr, wake_source_flags;
   logic reset_output, primary_safe_state_out, secondary_safe_state_out;
   logic irq_output_pin, wake_tmr_run;
   logic [2:0] sup_en, sup_restart, state_code;
   logic [3:0] reg_en;
   logic [9:0] wwd_first_win_ms;
   int fail_count = 0;
   int n_compared = 0;
   int cyc_cnt = 0;

   // short step keeps every delay at most 64 cycles long
   sstf_supply_fsm #(.STEP_CYC(4)) sstf_supply_fsm_inst (.clk_sys(clk_sys), .rst(rst), .ce(ce),
      .spi_sck(spi_sck), .spi_mosi(spi_mosi), .spi_chip_select(spi_chip_select),
      .power_on_release(power_on_release), .edge_wake_input(edge_wake_input),
      .level_resume_input(level_resume_input), .ldo_cur_low(ldo_cur_low),
      .ldo_cur_high(ldo_cur_high), .wake_tmr_expired(wake_tmr_expired),
      .severe_fail(severe_fail), .cfg(cfg), .wake_flags_clr(wake_flags_clr),
      .reset_output(reset_output), .primary_safe_state_out(primary_safe_state_out),
      .secondary_safe_state_out(secondary_safe_state_out), .irq_output_pin(irq_output_pin),
      .sup_en(sup_en), .sup_restart(sup_restart), .reg_en(reg_en), .wake_tmr_run(wake_tmr_run),
      .wake_source_flags(wake_source_flags), .wwd_first_win_ms(wwd_first_win_ms),
      .state_code(state_code));
   sstf_spi_ctrl sstf_spi_ctrl_inst (.spi_sck(spi_sck), .spi_mosi(spi_mosi),
      .spi_chip_select(spi_chip_select));

   ////////////////////////////////////////////////////////////////////////////
   // system clock, 8 ns
   initial
   begin
      clk_sys = 1'b0;
      forever #4 clk_sys = ~clk_sys;
   end

   // hang guard, a little above the expected run length
   always @(posedge clk_sys)
   begin
      cyc_cnt++;
      if (cyc_cnt == 80000)
      begin
         fail_count++;
         wrap_up();
      end
   end

   task automatic wrap_up();
      $display("compared %0d, mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : wrap_up

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("wrong value at %0t: saw %0h expected %0h", $time, seen, exp);
      end
   endtask : check

   task automatic cyc(input int n);
      repeat (n) @(negedge clk_sys);
   endtask : cyc

   // bounded poll for a state, sampled at falling edges
   task automatic wait_st(input logic [2:0] s, input int lim, output int n);
      n = 0;
      while (state_code !== s && n < lim)
      begin
         @(negedge clk_sys);
         n++;
      end
      check(state_code, s);
   endtask : wait_st

   ////////////////////////////////////////////////////////////////////////////
   // reset, release, refused frames, then a proper go-normal
   task automatic to_normal(input sstf_cfg_s c);
      int n;
      @(negedge clk_sys);
      rst = 1'b1;
      {power_on_release, edge_wake_input, level_resume_input} = 3'h0;
      {ldo_cur_low, ldo_cur_high, wake_tmr_expired, severe_fail} = 4'h0;
      cfg = c;
      cyc(5);
      rst = 1'b0;
      cyc(10);
      check(state_code, 3'h0);
      check({reset_output, primary_safe_state_out, secondary_safe_state_out}, 3'h0);
      power_on_release = 1'b1;
      wait_st(3'h1, 10, n);
      check(reset_output, 1'b1);
      sstf_spi_ctrl_inst.send(CMD_GO_SLEEP, 1);
      sstf_spi_ctrl_inst.send(CMD_GO_NORMAL, 2);
      cyc(10);
      check(state_code, 3'h1);
      sstf_spi_ctrl_inst.go_normal();
      wait_st(3'h2, 20, n);
      check({reset_output, primary_safe_state_out, secondary_safe_state_out}, 3'h7);
   endtask : to_normal

   // go-sleep frame watched from its first cycle
   task automatic go_sleep(input sstf_cfg_s c);
      int n;
      to_normal(c);
      // the frame's tail runs on so the first transition cycle is seen
      fork
         sstf_spi_ctrl_inst.send(CMD_GO_SLEEP, 1);
      join_none
      wait_st(3'h3, 400, n);
      check(spi_chip_select, 1'b1);
      check({reset_output, primary_safe_state_out, secondary_safe_state_out}, 3'h5);
      check(sup_en, c.sleep_sup);
   endtask : go_sleep

   // full trip to sleep and back to wake by one of five causes
   task automatic sleep_run(input int cause);
      sstf_cfg_s c;
      int n;
      int m;
      logic [2:0] rs;
      c = '0;
      c.tr_delay = 4'h2;
      c.cur_mon_sel = (cause == 3);
      c.wake_tmr_en = 1'b1;
      c.wd_cyc_sel = cause[0];
      c.norm_sup = cause[0] ? 3'h5 : 3'h7;
      c.sleep_sup = cause[0] ? 3'h1 : 3'h2;
      c.norm_reg = 4'hB;
      c.sleep_reg = 4'h2;
      go_sleep(c);
      ldo_cur_low = (cause == 3);
      n = 0;
      m = 0;
      while (state_code !== 3'h4 && n < 40)
      begin
         @(negedge clk_sys);
         n++;
         if (secondary_safe_state_out !== 1'b0)
            m = n;
      end
      if (cause == 3)
         check(n < 8, 1'b1);
      else
         check(n inside {[10:14]}, 1'b1);
      if (cause != 3)
         check(m inside {[2:5]}, 1'b1);
      check({primary_safe_state_out, secondary_safe_state_out, wake_tmr_run}, 3'h1);
      ldo_cur_low = 1'b0;
      case (cause)
         // the frame runs beside the poll so the pulse is counted from its start
         0:
            fork
               sstf_spi_ctrl_inst.send(CMD_GO_WAKE, 1);
            join_none
         1: edge_wake_input = 1'b1;
         2: level_resume_input = 1'b1;
         3: ldo_cur_high = 1'b1;
         default: wake_tmr_expired = 1'b1;
      endcase
      wait_st(3'h5, 60, n);
      check(irq_output_pin, 1'b1);
      check(wake_source_flags, 5'h01 << cause);
      check({sup_en, reg_en}, {c.norm_sup, c.norm_reg});
      check({wake_tmr_run, primary_safe_state_out, secondary_safe_state_out}, 3'h0);
      check(reset_output, 1'b1);
      check(wwd_first_win_ms, c.wd_cyc_sel ? WWD_LONG_MS : WWD_SHORT_MS);
      // restart pulses counted only once the interrupt is down
      m = 1;
      rs = 3'h0;
      repeat (IRQ_CYC + 3)
      begin
         @(negedge clk_sys);
         if (irq_output_pin === 1'b1)
            m++;
         else
            rs = rs | sup_restart;
      end
      check(m, IRQ_CYC);
      check(rs, {c.norm_sup[2:1], c.norm_sup[0] & ~c.sleep_sup[0]});
      {edge_wake_input, level_resume_input, ldo_cur_high, wake_tmr_expired} = 4'h0;
      $display("sleep run %0d done", cause);
   endtask : sleep_run

   // flag clear, then a severe failure from wake
   task automatic fail_run();
      int n;
      wake_flags_clr = 5'h1F;
      cyc(1);
      wake_flags_clr = 5'h00;
      cyc(1);
      check(wake_source_flags, 5'h00);
      // enable low freezes the sync chain, so the failure waits for it
      ce = 1'b0;
      severe_fail = 1'b1;
      cyc(6);
      check(state_code, 3'h5);
      ce = 1'b1;
      wait_st(3'h6, 10, n);
      check({reset_output, primary_safe_state_out, secondary_safe_state_out}, 3'h0);
      check({sup_en, reg_en, wake_tmr_run}, 8'h00);
      $display("failsafe run done");
   endtask : fail_run

   // leave the transition early: edge, level, or current still high at expiry
   task automatic tr_exit(input int kind);
      sstf_cfg_s c;
      int n;
      c = '0;
      c.tr_delay = 4'hF;
      c.ss2_delay = 4'hF;
      c.cur_mon_sel = (kind == 2);
      go_sleep(c);
      cyc(40);
      check(state_code, 3'h3);
      edge_wake_input = (kind == 0);
      level_resume_input = (kind == 1);
      wait_st(3'h5, 40, n);
      check({irq_output_pin, primary_safe_state_out, secondary_safe_state_out}, 3'h4);
      $display("transition exit %0d done", kind);
   endtask : tr_exit

   ////////////////////////////////////////////////////////////////////////////
   // main sequence
   initial
   begin
      {rst, ce, power_on_release, edge_wake_input, level_resume_input} = 5'h18;
      {ldo_cur_low, ldo_cur_high, wake_tmr_expired, severe_fail} = 4'h0;
      cfg = '0;
      wake_flags_clr = 5'h00;
      for (int k = 0; k < 5; k++)
         sleep_run(k);
      fail_run();
      for (int k = 0; k < 3; k++)
         tr_exit(k);
      wrap_up();
   end
endmodule : tb_sstf_supply_fsm
